// File: amb_map.svh
// alert mask bank: offsets, field positions, writable bit masks, link opcodes
// assumes inclusion by both ends, the checker and the bench; definitions only
`ifndef AMB_MAP_SVH
`define AMB_MAP_SVH
`define AMB_CMD_ALERT_MASK   8'h1B
`define AMB_SUB_IOUT         8'h7B
`define AMB_SUB_INPUT        8'h7C
`define AMB_SUB_TEMP         8'h7D
`define AMB_SUB_CML          8'h7E
`define AMB_PHASE_ALL        8'hFF
`define AMB_WMASK_IOUT       8'hB0
`define AMB_WMASK_INPUT      8'h08
`define AMB_WMASK_TEMP       8'hC0
`define AMB_WMASK_CML        8'hF2
`define AMB_BIT_OC_FAULT     7
`define AMB_BIT_OC_WARN      5
`define AMB_BIT_UC_FAULT     4
`define AMB_BIT_LOW_VIN      3
`define AMB_BIT_OT_FAULT     7
`define AMB_BIT_OT_WARN      6
`define AMB_BIT_INV_CMD      7
`define AMB_BIT_INV_DATA     6
`define AMB_BIT_PEC          5
`define AMB_BIT_MEM          4
`define AMB_BIT_OTHER_COMM   1
`define AMB_REG_CTRL         4'h0
`define AMB_REG_STATUS       4'h1
`define AMB_REG_RDATA        4'h2
`define AMB_REG_IRQ_STAT     4'h3
`define AMB_REG_IRQ_MASK     4'h4
`define AMB_REG_PHASE        4'h5
`define AMB_CTRL_GO          0
`define AMB_CTRL_READ        1
`endif

// File: amb_pkg.sv
// alert mask bank: shared types for both ends
// assumes amb_map.svh holds the numeric constants
package amb_pkg;
   // link operation requested by the host
   typedef enum logic [1:0] {
      AMB_OP_WRITE = 2'h1, // write word: low sub-command, high mask
      AMB_OP_READ  = 2'h2  // process call: one byte out, one byte back
   } amb_op_t;
   // four mask bytes, one per status group
   typedef struct packed {
      logic [7:0] iout;
      logic [7:0] input_grp;
      logic [7:0] temp;
      logic [7:0] cml;
   } amb_masks_t;
endpackage : amb_pkg

// File: amb_if.sv
// alert mask bank: link between host controller and device end
// assumes one clock, core_clk, shared by both ends
interface amb_if;
   logic       req;      // one-cycle request pulse from host
   amb_pkg::amb_op_t op; // write or read
   logic [7:0] cmd;      // command code
   logic [7:0] phase;    // phase selection held by host
   logic [7:0] sub;      // status sub-command byte
   logic [7:0] wdata;    // mask byte for writes
   logic       ack;      // one-cycle answer pulse from device
   logic       nak;      // request refused, with ack
   logic [7:0] rdata;    // read-back mask byte, valid with ack
   modport host (output req, op, cmd, phase, sub, wdata, input ack, nak, rdata);
   modport dev  (input req, op, cmd, phase, sub, wdata, output ack, nak, rdata);
endinterface : amb_if

// File: amb_device.sv
// alert mask bank: device end, mask bytes and alert gating
// assumes host keeps the link protocol; nvm copy stable during reset release
`include "amb_map.svh"

module amb_device (
   input  wire logic              core_clk,
   input  wire logic              rst,
   amb_if.dev                     link,
   input  wire amb_pkg::amb_masks_t nvm_masks,
   input  wire logic [31:0]       status_bits,
   output      amb_pkg::amb_masks_t masks,
   output      logic [31:0]       status_seen,
   output      logic              alert
);
   // sub-command code of each group, in the packed order of masks
   // other groups of the mask command belong to other blocks, refused here
   localparam logic [7:0] SUB [4] = '{
      `AMB_SUB_IOUT,
      `AMB_SUB_INPUT,
      `AMB_SUB_TEMP,
      `AMB_SUB_CML
   };

   // writable bits of each group; every other position is read-only zero
   //   iout:  overcurrent_fault_mask 7, overcurrent_warning_mask 5,
   //          undercurrent_fault_mask 4
   //   input: low_input_voltage_mask 3
   //   temp:  over_temp_fault_mask 7, over_temp_warning_mask 6
   //   cml:   invalid_command_mask 7, invalid_data_mask 6,
   //          packet_check_error_mask 5, memory_fault_mask 4,
   //          other_comm_fault_mask 1
   localparam logic [7:0] WMASK [4] = '{
      `AMB_WMASK_IOUT,
      `AMB_WMASK_INPUT,
      `AMB_WMASK_TEMP,
      `AMB_WMASK_CML
   };

   // internal decode and storage
   logic       loaded;      // nvm copy taken since reset
   logic       cmd_ok;      // command code is the mask command
   logic       phase_ok;    // phase selection is all phases
   logic [3:0] sel_hit;     // one-hot group hit, bit 0 is iout
   logic       sel_ok;      // command, phase and sub-command valid
   logic [7:0] sel_wmask;   // writable bits of addressed byte
   logic [7:0] sel_val;     // current value of addressed byte
   logic       wr_take;     // accepted write in this cycle
   logic       rd_take;     // accepted read in this cycle
   logic [7:0] grp_val [4]; // stored mask byte per group
   logic [3:0] grp_alert;   // unmasked condition present per group

   // command check; the bank accepts only its own mask command
   assign cmd_ok   = (link.cmd == `AMB_CMD_ALERT_MASK);

   // phase check; the mask bytes are not phased, so any phase other
   // than all-phases is refused outright rather than quietly ignored
   assign phase_ok = (link.phase == `AMB_PHASE_ALL);

   // decode of addressed byte; sub-commands outside the bank hit nothing,
   // which leaves sel_hit zero and makes the request a refusal
   always_comb begin
      sel_hit   = 4'h0;
      sel_wmask = 8'h00;
      sel_val   = 8'h00;
      for (int g = 0; g < 4; g++) begin
         if (link.sub == SUB[g]) begin
            sel_hit[g] = 1'b1;
            sel_wmask  = WMASK[g];
            sel_val    = grp_val[g];
         end
      end
   end

   // request qualification; a refused request leaves the mask bytes and rdata unchanged
   assign sel_ok  = cmd_ok && phase_ok && (|sel_hit);

   // accepted write: the host sends sub-command low, mask byte high;
   // the new byte stands from the same edge at which ack rises
   assign wr_take = link.req && (link.op == amb_pkg::AMB_OP_WRITE) && sel_ok;

   // accepted read: the host sends the sub-command, one byte comes back
   assign rd_take = link.req && (link.op == amb_pkg::AMB_OP_READ) && sel_ok;

   // nvm load marker; high from the first edge after reset release on
   // limitation: nvm_masks must be stable at that edge; later changes to
   // the stored copy are not seen until the next reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         loaded <= 1'b0;
      end else begin
         loaded <= 1'b1;
      end
   end

   // one mask byte per status group; the groups differ only in their
   // sub-command and writable bits, so one loop body serves all four
   // group index follows the packed order: 0 iout, 1 input, 2 temp, 3 cml
   for (genvar g = 0; g < 4; g++) begin : g_grp
      localparam int LANE = 24 - 8 * g; // low bit of this group in packed order
      logic [7:0] byte_q;    // stored mask byte, writable bits only
      logic [7:0] nvm_byte;  // nvm copy of this byte
      logic [7:0] stat_byte; // live status conditions of this group

      // lanes of the packed inputs that belong to this group
      assign nvm_byte  = nvm_masks[LANE +: 8];
      assign stat_byte = status_bits[LANE +: 8];

      // mask byte storage; reset loads zero and the nvm copy follows one
      // edge after release, because an async reset may only load constants
      // limitation: a write in that first edge would be overtaken by the
      // nvm copy, so the host must wait one edge after reset release
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            byte_q <= 8'h00;
         end else if (!loaded) begin
            byte_q <= nvm_byte & WMASK[g];
         end else if (wr_take && sel_hit[g]) begin
            // only writable bits take the written value; the rest stay zero
            byte_q <= link.wdata & WMASK[g];
         end
      end

      // a set mask bit hides its condition from the alert, a clear bit
      // passes it; the status byte itself is never touched here
      assign grp_alert[g] = |(stat_byte & ~byte_q);

      // stored byte for read-back and for the packed output
      assign grp_val[g] = byte_q;
   end

   // packed view of the four stored bytes, iout in the top lane;
   // each lane comes straight from its byte register
   assign masks = {grp_val[0], grp_val[1], grp_val[2], grp_val[3]};

   // link timing seen from the device:
   //   edge n   req, op, sub and wdata sampled together
   //   edge n   ack, with nak for a refusal, and rdata for a read
   //   edge n   the mask byte of an accepted write takes its new value
   // the host keeps at least two cycles between requests, so ack never
   // needs to stand for more than one cycle

   // acknowledge: one cycle after every request, taken or refused
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         link.ack <= 1'b0;
      end else begin
         link.ack <= link.req;
      end
   end

   // refusal flag, raised beside ack for a bad command, phase or group
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         link.nak <= 1'b0;
      end else begin
         link.nak <= link.req && !sel_ok;
      end
   end

   // read-back byte; held until the next accepted read so a slow host
   // can still pick it up, and unsupported positions always read zero
   // a refused read leaves the previous byte in place
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         link.rdata <= 8'h00;
      end else if (rd_take) begin
         link.rdata <= sel_val & sel_wmask;
      end
   end

   // status copy passes through untouched; masking never stops a status
   // bit from being set, it only keeps the bit away from the alert
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         status_seen <= '0;
      end else begin
         status_seen <= status_bits;
      end
   end

   // alert level; an unmasked condition of any group raises it
   // registered so the output carries no decode glitches, at the cost
   // of one cycle of latency after a status change
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         alert <= 1'b0;
      end else begin
         alert <= |grp_alert;
      end
   end
endmodule : amb_device

// File: amb_host.sv
// alert mask bank: host end, drives mask commands from software registers
// assumes software uses the plain strobe port; device answers in one cycle
`include "amb_map.svh"
module amb_host (
   input  wire logic       core_clk,
   input  wire logic       rst,
   amb_if.host             link,
   input  wire logic [3:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output      logic [31:0] rdata,
   output      logic       irq
);
   typedef enum logic [1:0] {
      AMB_H_IDLE = 2'b01, // waiting for go
      AMB_H_WAIT = 2'b10  // request out, awaiting ack
   } amb_hstate_t;
   amb_hstate_t state;
   logic [31:0] ctrl;     // [15:8] sub, [23:16] data, bit1 read
   logic [7:0]  rbyte;    // last read-back byte
   logic        nak_seen; // last answer refused
   logic [1:0]  ist;      // sticky: done, refused
   logic [1:0]  imask;    // enable per event
   logic [7:0]  phase;    // phase select, reset to all

   wire go   = wr && addr == `AMB_REG_CTRL && wdata[`AMB_CTRL_GO];
   wire done = state == AMB_H_WAIT && link.ack;

   // sequencer issuing one request per go
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state    <= AMB_H_IDLE;
         link.req <= 1'b0;
         link.op  <= amb_pkg::AMB_OP_WRITE;
         link.cmd <= 8'h00;
         link.sub <= 8'h00;
         link.wdata <= 8'h00;
         rbyte    <= 8'h00;
         nak_seen <= 1'b0;
      end else begin
         link.req <= 1'b0;
         unique case (state)
            AMB_H_IDLE: if (go) begin
               link.req   <= 1'b1;
               link.cmd   <= `AMB_CMD_ALERT_MASK;
               link.op    <= wdata[`AMB_CTRL_READ] ? amb_pkg::AMB_OP_READ
                                                   : amb_pkg::AMB_OP_WRITE;
               link.sub   <= wdata[15:8];
               link.wdata <= wdata[23:16];
               state      <= AMB_H_WAIT;
            end
            AMB_H_WAIT: if (link.ack) begin
               rbyte    <= link.rdata;
               nak_seen <= link.nak;
               state    <= AMB_H_IDLE;
            end
         endcase
      end
   end

   // software registers; phase register kept at FFh by default
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl  <= 32'h0;
         imask <= 2'h0;
         phase <= `AMB_PHASE_ALL;
      end else if (wr) begin
         if (addr == `AMB_REG_CTRL)     ctrl  <= wdata;
         if (addr == `AMB_REG_IRQ_MASK) imask <= wdata[1:0];
         if (addr == `AMB_REG_PHASE)    phase <= wdata[7:0];
      end
   end
   assign link.phase = phase;

   // sticky events; set beats read clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ist <= 2'h0;
      end else begin
         ist <= ((rd && addr == `AMB_REG_IRQ_STAT) ? 2'h0 : ist)
                | {done && link.nak, done};
      end
   end

   // read data one cycle after strobe, and irq level
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h0;
         irq   <= 1'b0;
      end else begin
         irq <= |(ist & imask);
         if (rd) begin
            unique case (addr)
               `AMB_REG_CTRL:     rdata <= ctrl;
               `AMB_REG_STATUS:   rdata <= {30'h0, nak_seen, state == AMB_H_WAIT};
               `AMB_REG_RDATA:    rdata <= {24'h0, rbyte};
               `AMB_REG_IRQ_STAT: rdata <= {30'h0, ist};
               `AMB_REG_IRQ_MASK: rdata <= {30'h0, imask};
               `AMB_REG_PHASE:    rdata <= {24'h0, phase};
               default:           rdata <= 32'h0;
            endcase
         end else begin
            rdata <= 32'h0;
         end
      end
   end
endmodule : amb_host

// File: amb_props.sv
// alert mask bank checker: link answer timing and read-back fields
// assumes instantiation beside the link interface, one clock domain
`include "amb_map.svh"
module amb_props (
   input wire logic             core_clk,
   input wire logic             rst,
   input wire logic             req,
   input wire amb_pkg::amb_op_t op,
   input wire logic [7:0]       cmd,
   input wire logic [7:0]       phase,
   input wire logic [7:0]       sub,
   input wire logic             ack,
   input wire logic             nak,
   input wire logic [7:0]       rdata
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // request the device must take: right command, phase and group
   wire good = cmd == `AMB_CMD_ALERT_MASK && phase == `AMB_PHASE_ALL
               && sub >= `AMB_SUB_IOUT && sub <= `AMB_SUB_CML;
   // accepted read, the only case where rdata may take a new value
   wire rd_ok = req && good && op == amb_pkg::AMB_OP_READ;

   chk_ok_taken: assert property (req && good |=> ack && !nak)
      else $error("accepted request not answered");
   chk_bad_refused: assert property (req && !good |=> ack && nak)
      else $error("bad request not refused");
   chk_ack_single: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   chk_req_pulse: assert property (req |=> !req)
      else $error("request longer than one cycle");
   chk_rd_iout: assert property (rd_ok && sub == `AMB_SUB_IOUT |=> (rdata & 8'h4F) == 0)
      else $error("current mask reads unsupported bit");
   chk_rd_input: assert property (rd_ok && sub == `AMB_SUB_INPUT |=> (rdata & 8'hF7) == 0)
      else $error("input mask reads unsupported bit");
   chk_rd_temp: assert property (rd_ok && sub == `AMB_SUB_TEMP |=> rdata[5:0] == 0)
      else $error("temperature mask low bits not zero");
   chk_rd_cml: assert property (rd_ok && sub == `AMB_SUB_CML |=> (rdata & 8'h0D) == 0)
      else $error("comm mask reads unsupported bit");
   chk_nak_in_ack: assert property (nak |-> ack)
      else $error("refusal without acknowledge");
   chk_rdata_holds: assert property (!rd_ok |=> $stable(rdata))
      else $error("read-back byte changed without a read");
endmodule : amb_props

// File: alert_mask_bank_test.sv
// alert mask bank bench: host and device joined, driven via the software port
// assumes the design files and amb_props.sv compile first
`include "amb_map.svh"
module alert_mask_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                core_clk = 0, rst = 1, wr = 0, rd = 0;
   logic [3:0]          addr = 0;
   logic [31:0]         wdata = 0, status_bits = 0, rdata, status_seen;
   amb_pkg::amb_masks_t nvm_masks = 0, masks;
   logic                irq, alert;
   int                  err_count, n_checks, im, m[4]; // counts, irq mask, mask model
   int                  wm[4] = '{8'hB0, 8'h08, 8'hC0, 8'hF2}; // writable bits
   always #2 core_clk = ~core_clk;
   amb_if u_amb_if ();
   amb_host u_amb_host (.core_clk, .rst, .link(u_amb_if), .addr, .wdata, .wr, .rd,
      .rdata, .irq);
   amb_device u_amb_device (.core_clk, .rst, .link(u_amb_if), .nvm_masks,
      .status_bits, .masks, .status_seen, .alert);
   amb_props u_amb_props (.core_clk, .rst, .req(u_amb_if.req), .op(u_amb_if.op),
      .cmd(u_amb_if.cmd), .phase(u_amb_if.phase), .sub(u_amb_if.sub),
      .ack(u_amb_if.ack), .nak(u_amb_if.nak), .rdata(u_amb_if.rdata));
   // compare and count
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   // one-cycle software write
   task automatic wrr(logic [3:0] a, logic [31:0] d);
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1;
      @(posedge core_clk);
      wr <= 0;
   endtask : wrr
   // software read, data taken in the cycle after the strobe only
   task automatic rdr(logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      rd   <= 1;
      @(posedge core_clk);
      rd <= 0;
      #1 d = rdata;
   endtask : rdr
   // all four mask bytes against the model
   task automatic chkm();
      for (int i = 0; i < 4; i++) chk("masks", m[i], masks[31-8*i -: 8]);
   endtask : chkm
   // one link transfer; fixed wait covers the c0..c4 walk
   task automatic xfer(logic [7:0] s, logic [7:0] v, logic r, logic bad);
      logic [31:0] d;
      int          i;
      i = s - 8'h7B;
      wrr(`AMB_REG_CTRL, {8'h00, v, s, 6'h00, r, 1'b1});
      repeat (6) @(posedge core_clk);
      chk("irq", im != 0, irq);
      rdr(`AMB_REG_STATUS, d);
      chk("status", {30'h0, bad, 1'b0}, d);
      rdr(`AMB_REG_IRQ_STAT, d);
      chk("refused", bad, d[1]);
      chk("done", 1, d[0]);
      repeat (2) @(posedge core_clk);
      chk("irq clear", 0, irq);
      if (!bad && !r) m[i] = v & wm[i];
      if (!bad && r) begin
         rdr(`AMB_REG_RDATA, d);
         chk("rbyte", m[i], d[7:0]);
      end
      chkm();
   endtask : xfer
   // random status; half the time only masked bits, so alert must stay low
   task automatic alrt(logic only_masked);
      logic [31:0] k;
      logic [31:0] s;
      k = {m[0][7:0], m[1][7:0], m[2][7:0], m[3][7:0]};
      s = $urandom;
      if (only_masked) s &= k;
      @(posedge core_clk);
      status_bits <= s;
      repeat (4) @(posedge core_clk);
      chk("seen", s, status_seen);
      chk("alert", |(s & ~k), alert);
   endtask : alrt
   // verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   initial begin
      void'($urandom(32'hE379A4B5));
      @(posedge core_clk);
      nvm_masks <= $urandom;
      repeat (15) @(posedge core_clk);
      rst <= 0;
      repeat (2) @(posedge core_clk);
      for (int i = 0; i < 4; i++) m[i] = nvm_masks[31-8*i -: 8] & wm[i];
      chkm();
      $display("test reset load done");
      im = 3;
      wrr(`AMB_REG_IRQ_MASK, 3);
      // every group written all-ones first, then random, each read back
      for (int j = 0; j < 16; j++) begin
         xfer(8'(8'h7B + j % 4), j < 4 ? 8'hFF : 8'($urandom), 0, 0);
         xfer(8'(8'h7B + j % 4), 8'h00, 1, 0);
         alrt(j[0]);
      end
      $display("test write read alert done");
      // neighbours of the group range and a wrong phase are refused
      im = 0;
      wrr(`AMB_REG_IRQ_MASK, 0);
      xfer(8'h7A, 8'hFF, 0, 1);
      xfer(8'h7F, 8'hFF, 0, 1);
      wrr(`AMB_REG_PHASE, 32'h00000000);
      xfer(8'h7D, 8'hFF, 0, 1);
      xfer(8'h7D, 8'h00, 1, 1);
      wrr(`AMB_REG_PHASE, 32'h000000FF);
      xfer(8'h7C, 8'hFF, 0, 0);
      $display("test refusal done");
      // second reset in mid-run with a fresh nvm copy; masks reload from it
      @(posedge core_clk);
      rst       <= 1;
      nvm_masks <= $urandom;
      repeat (4) @(posedge core_clk);
      rst <= 0;
      repeat (2) @(posedge core_clk);
      for (int i = 0; i < 4; i++) m[i] = nvm_masks[31-8*i -: 8] & wm[i];
      chkm();
      xfer(8'h7E, 8'($urandom), 0, 0);
      xfer(8'h7E, 8'h00, 1, 0);
      $display("test second reset done");
      final_report();
   end
endmodule : alert_mask_bank_test
